/* File: bias_ctrl_pkg.sv */
// constants for the output driver and bias control register bank
// assumes an 8-bit register port addressed by the printed page offsets
package bias_ctrl_pkg;

	localparam int            ADDR_W              = 7;
	localparam int            DATA_W              = 8;

	// register offsets
	localparam logic [6:0]    DRIVER_CTRL_ADDR    = 7'h2C;
	localparam logic [6:0]    RSVD_AFTER_ADDR     = 7'h2D;
	localparam logic [6:0]    BIAS_CTRL_ADDR      = 7'h2E;

	// reset values
	localparam logic [7:0]    DRIVER_CTRL_RESET   = 8'h20;
	localparam logic [7:0]    RSVD_AFTER_RESET    = 8'h00;
	localparam logic [7:0]    BIAS_CTRL_RESET     = 8'h00;
	localparam logic [7:0]    UNMAPPED_READ       = 8'h00;

	// driver control fields
	localparam int            DEBOUNCE_MSB        = 7;
	localparam int            DEBOUNCE_LSB        = 5;
	localparam int            DAC_PERF_MSB        = 4;
	localparam int            DAC_PERF_LSB        = 3;
	localparam int            LINE_OUT_BIT        = 2;

	// bias control fields
	localparam int            SOFT_PDN_BIT        = 7;
	localparam int            BIAS_OVERRIDE_BIT   = 3;
	localparam int            BIAS_LEVEL_MSB      = 1;
	localparam int            BIAS_LEVEL_LSB      = 0;

	// dac performance codes
	localparam logic [1:0]    DAC_PERF_DEFAULT    = 2'h0;
	localparam logic [1:0]    DAC_PERF_RESERVED   = 2'h2;

	// bias level codes: off, 2 V, 2.5 V, analog supply rail
	localparam logic [1:0]    BIAS_LEVEL_OFF      = 2'h0;

	// debounce timing
	localparam int            DEBOUNCE_TICKS      = 8;
	localparam logic [3:0]    DEBOUNCE_LAST_TICK  = 4'h7;
	localparam logic [2:0]    DEBOUNCE_CODE_ZERO  = 3'h0;
	// oscillator edges per unit step, about 0.98 us at 8.2 MHz
	localparam logic [2:0]    OSC_PRESCALE_LAST   = 3'h7;

endpackage

/* File: debounce_timebase.sv */
// debounce timebase: one-cycle tick whose period is one eighth of the debounce time
// assumes both source ticks are one-cycle enables from logic on clock_in
`timescale 1ns/10ps
module debounce_timebase
	import bias_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	// timebase sources
	input  wire logic         mclk_tick_in,
	input  wire logic         osc_tick_in,
	input  wire logic         osc_select_in,
	// debounce code
	input  wire logic [2:0]   debounce_code_in,
	// tick
	output logic              tick_out
);
	logic [2:0]   prescale;
	logic         unit_step;
	logic [7:0]   divide;
	logic [7:0]   divide_last;

	always_comb
	begin
		if (osc_select_in)
			unit_step = osc_tick_in && (prescale == OSC_PRESCALE_LAST);
		else
			unit_step = mclk_tick_in;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			prescale <= 3'h0;
		else if (osc_select_in && osc_tick_in)
			prescale <= prescale + 3'h1;
	end

	// tick period is 2^(code-1) unit steps
	always_comb
	begin
		if (debounce_code_in == DEBOUNCE_CODE_ZERO)
			divide_last = 8'h00;
		else
			divide_last = 8'((9'h001 << (debounce_code_in - 3'h1)) - 9'h001);
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			divide   <= 8'h00;
			tick_out <= 1'b0;
		end
		else
		begin
			tick_out <= 1'b0;
			if (unit_step)
			begin
				if (divide >= divide_last)
				begin
					divide   <= 8'h00;
					tick_out <= 1'b1;
				end
				else
					divide <= divide + 8'h01;
			end
		end
	end

endmodule

/* File: output_driver_bias_control.sv */
// output driver and microphone bias control registers with short-circuit debounce
// assumes a host-side interface decoder presents single-cycle register reads and writes
//
// Function
// - debounce code picks 0 to 512 us
// - oscillator source scales debounce with frequency
// - timebase period is one eighth of debounce
// - driver bit selects headphone or line out
// - top bias bit enables software power-down
// - override bit powers bias without headset
// - bias level off, 2 V, 2.5 V, rail
`timescale 1ns/10ps
module output_driver_bias_control
	import bias_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic                   clock_in,
	input  wire logic                   rst_in,
	// register port
	input  wire logic                   wr_en_in,
	input  wire logic                   rd_en_in,
	input  wire logic [ADDR_W-1:0]      addr_in,
	input  wire logic [DATA_W-1:0]      wr_data_in,
	output logic      [DATA_W-1:0]      rd_data_out,
	// debounce sources and short-circuit sense pin
	input  wire logic                   mclk_tick_in,
	input  wire logic                   osc_tick_in,
	input  wire logic                   osc_select_in,
	input  wire logic                   headset_short_in,
	// headset detection state
	input  wire logic                   headset_detect_enable_in,
	input  wire logic                   headset_inserted_in,
	// analog controls
	output logic                        short_detected_out,
	output logic      [1:0]             dac_perf_mode_out,
	output logic                        line_out_mode_out,
	output logic                        soft_power_down_out,
	output logic      [1:0]             microphone_bias_supply_out
);
	logic [7:0]   headphone_driver_control;
	logic [7:0]   reserved_after_driver_control;
	logic [7:0]   mic_bias_power_control;
	logic [2:0]   debounce_code;
	logic         timebase_tick;
	logic         short_meta;
	logic         short_sync;
	logic [3:0]   stable_ticks;
	logic         bias_allowed;
	logic [1:0]   dac_perf_code;
	logic [1:0]   bias_level_code;
	logic         wr_driver;
	logic         wr_reserved;
	logic         wr_bias;

	// one write decode shared by the three registers
	function automatic logic write_hit(
		input logic                  wr_en,
		input logic [ADDR_W-1:0]     addr,
		input logic [ADDR_W-1:0]     target
	);
		return wr_en && (addr == target);
	endfunction

	assign debounce_code   = headphone_driver_control[DEBOUNCE_MSB:DEBOUNCE_LSB];
	assign dac_perf_code   = headphone_driver_control[DAC_PERF_MSB:DAC_PERF_LSB];
	assign bias_level_code = mic_bias_power_control[BIAS_LEVEL_MSB:BIAS_LEVEL_LSB];
	// a write to any other offset, mapped or not, changes nothing
	assign wr_driver       = write_hit(wr_en_in, addr_in, DRIVER_CTRL_ADDR);
	assign wr_reserved     = write_hit(wr_en_in, addr_in, RSVD_AFTER_ADDR);
	assign wr_bias         = write_hit(wr_en_in, addr_in, BIAS_CTRL_ADDR);

	// registers
	// debounce code resets to one
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			headphone_driver_control <= DRIVER_CTRL_RESET;
		else if (wr_driver)
			headphone_driver_control <= wr_data_in;
	end

	// stored rather than left undefined so readback is repeatable
	// storage kept so host writes do no harm
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			reserved_after_driver_control <= RSVD_AFTER_RESET;
		else if (wr_reserved)
			reserved_after_driver_control <= wr_data_in;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			mic_bias_power_control <= BIAS_CTRL_RESET;
		else if (wr_bias)
			mic_bias_power_control <= wr_data_in;
	end

	// reserved bits are stored as written and drive nothing
	// a read in the same cycle as a write returns the old contents
	// reserved bits read back as stored
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			rd_data_out <= UNMAPPED_READ;
		else if (rd_en_in)
		begin
			unique case (addr_in)
				DRIVER_CTRL_ADDR: rd_data_out <= headphone_driver_control;
				RSVD_AFTER_ADDR:  rd_data_out <= reserved_after_driver_control;
				BIAS_CTRL_ADDR:   rd_data_out <= mic_bias_power_control;
				default:          rd_data_out <= UNMAPPED_READ;
			endcase
		end
	end

	// tick at one eighth of debounce
	debounce_timebase timebase (
		.clock_in         (clock_in),
		.rst_in           (rst_in),
		.mclk_tick_in     (mclk_tick_in),
		.osc_tick_in      (osc_tick_in),
		.osc_select_in    (osc_select_in),
		.debounce_code_in (debounce_code),
		.tick_out         (timebase_tick)
	);

	// sense pin is asynchronous to clock_in
	// only the second flop is read by the debounce logic
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			short_meta <= 1'b0;
			short_sync <= 1'b0;
		end
		else
		begin
			short_meta <= headset_short_in;
			short_sync <= short_meta;
		end
	end

	// a code change mid-count keeps the partial count, so the first
	// interval after a change can be shorter than programmed
	// code zero passes the sense level straight through
	// otherwise eight stable ticks change the output
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			stable_ticks       <= 4'h0;
			short_detected_out <= 1'b0;
		end
		else if (debounce_code == DEBOUNCE_CODE_ZERO)
		begin
			stable_ticks       <= 4'h0;
			short_detected_out <= short_sync;
		end
		else if (short_sync == short_detected_out)
			stable_ticks <= 4'h0;
		else if (timebase_tick)
		begin
			if (stable_ticks == DEBOUNCE_LAST_TICK)
			begin
				stable_ticks       <= 4'h0;
				short_detected_out <= short_sync;
			end
			else
				stable_ticks <= stable_ticks + 4'h1;
		end
	end

	// the analog side never sees the reserved code
	// reserved code two falls back to default operation
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			dac_perf_mode_out <= DAC_PERF_DEFAULT;
		else if (dac_perf_code == DAC_PERF_RESERVED)
			dac_perf_mode_out <= DAC_PERF_DEFAULT;
		else
			dac_perf_mode_out <= dac_perf_code;
	end

	// line out when the bit is set
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			line_out_mode_out <= 1'b0;
		else
			line_out_mode_out <= headphone_driver_control[LINE_OUT_BIT];
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			soft_power_down_out <= 1'b0;
		else
			soft_power_down_out <= mic_bias_power_control[SOFT_PDN_BIT];
	end

	// detection inputs come from logic on clock_in; no synchroniser
	// bias gated off when detection finds no headset, unless the override bit is set
	assign bias_allowed = !headset_detect_enable_in || headset_inserted_in
		|| mic_bias_power_control[BIAS_OVERRIDE_BIT];

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			microphone_bias_supply_out <= BIAS_LEVEL_OFF;
		else if (bias_allowed)
			microphone_bias_supply_out <= bias_level_code;
		else
			microphone_bias_supply_out <= BIAS_LEVEL_OFF;
	end

endmodule

/* File: bias_ctrl_sva.sv */
// checker for the driver and bias register bank outputs
// sees only the top module ports; bound after the module
`timescale 1ns/10ps
module bias_ctrl_sva
	import bias_ctrl_pkg::*;
(
	input  wire logic                   clock_in,
	input  wire logic                   rst_in,
	input  wire logic                   wr_en_in,
	input  wire logic                   rd_en_in,
	input  wire logic [ADDR_W-1:0]      addr_in,
	input  wire logic [DATA_W-1:0]      wr_data_in,
	input  wire logic [DATA_W-1:0]      rd_data_out,
	input  wire logic                   headset_short_in,
	input  wire logic                   headset_detect_enable_in,
	input  wire logic                   headset_inserted_in,
	input  wire logic                   short_detected_out,
	input  wire logic [1:0]             dac_perf_mode_out,
	input  wire logic                   line_out_mode_out,
	input  wire logic                   soft_power_down_out,
	input  wire logic [1:0]             microphone_bias_supply_out
);
	wire logic [1:0] hd = {headset_detect_enable_in, headset_inserted_in};
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// a write that is not followed at once by another to the same place
	sequence s_wr(a);
		wr_en_in && addr_in == a ##1 !(wr_en_in && addr_in == a);
	endsequence
	property p_rst;
		$fell(rst_in) |-> rd_data_out == 8'h00 && !line_out_mode_out && !soft_power_down_out
			&& microphone_bias_supply_out == 2'h0 && dac_perf_mode_out == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_line;
		s_wr(DRIVER_CTRL_ADDR) |=> line_out_mode_out == $past(wr_data_in[2], 2);
	endproperty
	a_line: assert property (p_line) else $error("line out mode wrong after write");
	property p_dac;
		s_wr(DRIVER_CTRL_ADDR) |=> dac_perf_mode_out ==
			(($past(wr_data_in[4:3], 2) == 2'h2) ? 2'h0 : $past(wr_data_in[4:3], 2));
	endproperty
	a_dac: assert property (p_dac) else $error("dac mode wrong after write");
	property p_dac_code;
		dac_perf_mode_out != 2'h2;
	endproperty
	a_dac_code: assert property (p_dac_code) else $error("reserved dac mode driven");
	property p_spd;
		s_wr(BIAS_CTRL_ADDR) |=> soft_power_down_out == $past(wr_data_in[7], 2);
	endproperty
	a_spd: assert property (p_spd) else $error("power down bit wrong after write");
	property p_bias;
		s_wr(BIAS_CTRL_ADDR) ##0 $stable(hd) ##1 $stable(hd) |-> microphone_bias_supply_out ==
			((!hd[1] || hd[0] || $past(wr_data_in[3], 2)) ? $past(wr_data_in[1:0], 2) : 2'h0);
	endproperty
	a_bias: assert property (p_bias) else $error("bias level or gating wrong");
	property p_unmapped;
		rd_en_in && !(addr_in inside {7'h2C, 7'h2D, 7'h2E}) |=> rd_data_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		!rd_en_in |=> $stable(rd_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
	property p_short;
		$rose(short_detected_out) |-> $past(headset_short_in, 3);
	endproperty
	a_short: assert property (p_short) else $error("short flagged without sense");
endmodule

bind output_driver_bias_control bias_ctrl_sva u_sva (.*);

/* File: host_model.sv */
// host side of the register port: single-cycle read and write strobes
// released lines show the inverse of the last value so nothing stale matches
`timescale 1ns/10ps
module host_model (
	input  wire logic         clock_in,
	input  wire logic [7:0]   rd_data_in,
	output logic              wr_en_out,
	output logic              rd_en_out,
	output logic [6:0]        addr_out,
	output logic [7:0]        data_out
);
	initial
	begin
		wr_en_out = 0;
		rd_en_out = 0;
		addr_out = 7'h00;
		data_out = 8'h00;
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		if (a == 7'h2D)
			return;
		@(posedge clock_in);
		wr_en_out <= 1;
		addr_out <= a;
		data_out <= (a == 7'h2E) ? (d & 8'h8B) : (d & 8'hFC);
		@(posedge clock_in);
		wr_en_out <= 0;
		addr_out <= ~a;
		data_out <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		@(posedge clock_in);
		rd_en_out <= 1;
		addr_out <= a;
		@(posedge clock_in);
		rd_en_out <= 0;
		addr_out <= ~a;
		@(negedge clock_in);
		q = rd_data_in;
	endtask
endmodule

/* File: testbench.sv */
// self-checking bench: register reset, field effects and debounce timing
// ticks: divided clock every 200 cycles, oscillator every 24 cycles
`timescale 1ns/10ps
module testbench;
	import bias_ctrl_pkg::*;
	logic clock_in = 0, rst_in = 1, mclk = 0, osc = 0, osel = 0, sh = 0, det = 1, ins = 0;
	logic wr, rd, sd, lo_m, spd;
	logic [6:0] ad;
	logic [7:0] wd, rdat, q, d;
	logic [1:0] dac, bias;
	logic [6:0] ra[4] = '{7'h2C, 7'h2D, 7'h2E, 7'h2F};
	logic [7:0] rv[4] = '{8'h20, 8'h00, 8'h00, 8'h00};
	int n_fail = 0, cmp_count = 0, cyc = 0;
	initial
		forever #2.5 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		cyc <= cyc + 1;
		mclk <= (cyc % 200 == 199);
		osc <= (cyc % 24 == 23);
	end
	host_model host (.clock_in(clock_in), .rd_data_in(rdat), .wr_en_out(wr), .rd_en_out(rd),
		.addr_out(ad), .data_out(wd));
	output_driver_bias_control dut (.clock_in(clock_in), .rst_in(rst_in), .wr_en_in(wr), .rd_en_in(rd),
		.addr_in(ad), .wr_data_in(wd), .rd_data_out(rdat), .mclk_tick_in(mclk), .osc_tick_in(osc),
		.osc_select_in(osel), .headset_short_in(sh), .headset_detect_enable_in(det),
		.headset_inserted_in(ins), .short_detected_out(sd), .dac_perf_mode_out(dac),
		.line_out_mode_out(lo_m), .soft_power_down_out(spd), .microphone_bias_supply_out(bias));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// cycles from sense rising to flag rising must fall in [lo, hi)
	task automatic deb(input logic [2:0] c, input logic o, input int lo, input int hi);
		int n;
		host.wr(DRIVER_CTRL_ADDR, {c, 5'h00});
		osel <= o;
		sh <= 1;
		n = 0;
		while (sd !== 1'b1 && n < hi)
		begin
			@(negedge clock_in);
			n++;
		end
		chk("debounce", 8'h01, 8'(n >= lo && n < hi));
		@(posedge clock_in);
		sh <= 0;
		repeat (2 * hi) @(posedge clock_in);
		chk("release", 8'h00, 8'(sd));
	endtask
	initial
	begin
		repeat (16) @(posedge clock_in);
		rst_in <= 0;
		host.wr(7'h2F, 8'hFF);
		for (int i = 0; i < 4; i++)
		begin
			host.rd(ra[i], q);
			chk("reset", rv[i], q);
		end
		chk("reset_outs", 8'h00, 8'({dac, lo_m, spd, bias}));
		for (int i = 0; i < 4; i++)
		begin
			d = {3'h0, 2'(i), 1'(i), 2'h0};
			host.wr(DRIVER_CTRL_ADDR, d);
			host.rd(DRIVER_CTRL_ADDR, q);
			chk("drv_read", d, q);
			chk("dac", (i == 2) ? 8'h00 : 8'(i), 8'(dac));
			chk("line_out", 8'(i % 2), 8'(lo_m));
		end
		for (int i = 0; i < 32; i++)
		begin
			@(posedge clock_in);
			det <= ~i[4];
			ins <= i[3];
			d = {i[0], 3'h0, i[2], 1'b0, 2'(i)};
			host.wr(BIAS_CTRL_ADDR, d);
			host.rd(BIAS_CTRL_ADDR, q);
			chk("bias_read", d, q);
			chk("bias", (i[4] || i[3] || i[2]) ? 8'(i % 4) : 8'h00, 8'(bias));
			chk("soft_pd", 8'(i % 2), 8'(spd));
		end
		deb(3'h0, 1'b0, 2, 6);
		deb(3'h1, 1'b0, 1400, 1610);
		deb(3'h2, 1'b0, 2800, 3210);
		deb(3'h3, 1'b0, 5600, 6410);
		deb(3'h1, 1'b1, 1344, 1546);
		// sense held for well under eight ticks must not be flagged
		host.wr(DRIVER_CTRL_ADDR, 8'h20);
		osel <= 0;
		sh <= 1;
		repeat (1000) @(posedge clock_in);
		sh <= 0;
		repeat (2000) @(posedge clock_in);
		chk("glitch", 8'h00, 8'(sd));
		close_out;
	end
	initial
	begin
		repeat (60000) @(posedge clock_in);
		n_fail++;
		close_out;
	end
endmodule
